/* File: rtl/dpisb_top.sv */
/*
  Dual-phase input signature self-test: DDR capture on the source data
  clock, receiver accumulators, a gray-pointer crossing FIFO into the
  system clock, post-FIFO accumulators and a serial register port.
  Assumes the source drives samples centred on both edges of its clock,
  and holds zero samples after a vector so trailing edges keep running.
*/
// Notes on behaviour
// - every accumulator is 32 bits and is read as one 32-bit signature.
// - on a nonzero sample bit 1 becomes xnor of old bit 32 and sample bit 1; zero holds.
// - bits 2 to 14 become xnor of the next lower old bit and the sample bit there.
// - bits 15 to 32 simply shift up from the next lower old bit.
// - select 00 shows the first-phase receiver sum, 01 the second-phase one.
// - the chosen signature is spread over four byte registers at 18 to 21.
// - at unity rate the post-FIFO sums equal the receiver sums of each phase.
// - samples alternate between two capture registers on the two clock edges.
// - one pair of sums follows the receiver, a second pair follows the crossing FIFO.
// - clear with both enables high zeroes the sums; clear must drop before a vector.
`timescale 1ns/1ps
module dpisb_top #(
  parameter int FIFO_DEPTH = 4
) (
  input  wire logic                           sys_clk_i,
  input  wire logic                           srst_i,
  input  wire logic                           ce_i,
  input  wire logic                           source_data_clock_i,
  input  wire logic [dpisb_pkg::SAMPLE_W-1:0] sample_data_i,
  input  wire logic                           spi_cs_n_i,
  input  wire logic                           spi_sclk_i,
  input  wire logic                           spi_sdi_i,
  output logic                                spi_sdo_o,
  output logic                                spi_sdo_oe_o
);

  localparam int PW = $clog2(FIFO_DEPTH) + 1;
  localparam int DW = 2 * dpisb_pkg::SAMPLE_W;

  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_bad_depth
    $error("FIFO_DEPTH must be a power of two of at least 2");
  end

  function automatic logic [PW-1:0] bin2gray(input logic [PW-1:0] b);
    return b ^ (b >> 1);
  endfunction

  function automatic logic [PW-1:0] gray2bin(input logic [PW-1:0] g);
    logic [PW-1:0] b;
    b = '0;
    for (int i = PW - 1; i >= 0; i--) begin
      b[i] = g[i] ^ ((i == PW - 1) ? 1'b0 : b[i + 1]);
    end
    return b;
  endfunction

  // ****************************************************************
  // system side declarations
  // ****************************************************************
  logic [dpisb_pkg::REG_W-1:0] bist_ctrl;
  logic [dpisb_pkg::SIG_W-1:0] rd_sig;
  logic [dpisb_pkg::SIG_W-1:0] xs_ph1;
  logic [dpisb_pkg::SIG_W-1:0] xs_ph2;
  logic [dpisb_pkg::SIG_W-1:0] post_ph1;
  logic [dpisb_pkg::SIG_W-1:0] post_ph2;
  logic                        ctl_clear;
  logic                        ctl_post_en;
  logic                        ctl_rx_en;
  logic                        signature_read_enable;
  logic [1:0]                  ctl_sel;

  assign ctl_clear             = bist_ctrl[dpisb_pkg::CTRL_CLEAR_BIT];
  assign ctl_post_en           = bist_ctrl[dpisb_pkg::CTRL_POST_EN_BIT];
  assign ctl_rx_en             = bist_ctrl[dpisb_pkg::CTRL_RX_EN_BIT];
  assign signature_read_enable = bist_ctrl[dpisb_pkg::CTRL_RD_EN_BIT];
  assign ctl_sel               = bist_ctrl[dpisb_pkg::CTRL_SEL_LSB +: 2];

  // ****************************************************************
  // link domain: reset and control synchronisers
  // ****************************************************************
  logic [1:0] lrst_q;
  logic [1:0] lclr_q;
  logic [1:0] len_q;
  logic       lrst;

  // levels from the system side, two flops each
  always_ff @(posedge source_data_clock_i) begin
    lrst_q <= {lrst_q[0], srst_i};
    lclr_q <= {lclr_q[0], ctl_clear};
    len_q  <= {len_q[0], ctl_rx_en};
  end
  assign lrst = lrst_q[1];

  // ****************************************************************
  // link domain: DDR capture
  // ****************************************************************
  logic [dpisb_pkg::SAMPLE_W-1:0] cap_ph1;
  logic [dpisb_pkg::SAMPLE_W-1:0] cap_ph2;

  // first phase on the rising edge
  always_ff @(posedge source_data_clock_i) begin
    cap_ph1 <= sample_data_i;
  end

  // second phase on the falling edge
  always_ff @(negedge source_data_clock_i) begin
    cap_ph2 <= sample_data_i;
  end

  // ****************************************************************
  // receiver accumulators, one per phase
  // ****************************************************************
  logic [dpisb_pkg::SIG_W-1:0] rx_ph1;
  logic [dpisb_pkg::SIG_W-1:0] rx_ph2;

  // both step on the rising edge after their sample is held
  dpisb_sig u_rx_ph1 (
    .clk_i     (source_data_clock_i),
    .rst_i     (lrst),
    .en_i      (len_q[1]),
    .clr_i     (lclr_q[1]),
    .smp_vld_i (1'b1),
    .smp_i     (cap_ph1),
    .sig_o     (rx_ph1)
  );

  dpisb_sig u_rx_ph2 (
    .clk_i     (source_data_clock_i),
    .rst_i     (lrst),
    .en_i      (len_q[1]),
    .clr_i     (lclr_q[1]),
    .smp_vld_i (1'b1),
    .smp_i     (cap_ph2),
    .sig_o     (rx_ph2)
  );

  // ****************************************************************
  // link domain: snapshot publisher for readback
  // ****************************************************************
  logic [dpisb_pkg::SIG_W-1:0] snap_ph1;
  logic [dpisb_pkg::SIG_W-1:0] snap_ph2;
  logic                        pub_tgl;
  logic [1:0]                  ack_q;
  logic                        ack_tgl;

  // refresh the snapshot once the system side took the last one
  always_ff @(posedge source_data_clock_i) begin
    ack_q <= {ack_q[0], ack_tgl};
    if (lrst) begin
      pub_tgl  <= 1'b0;
      snap_ph1 <= dpisb_pkg::SIG_RESET;
      snap_ph2 <= dpisb_pkg::SIG_RESET;
    end else if (pub_tgl == ack_q[1]) begin
      snap_ph1 <= rx_ph1;
      snap_ph2 <= rx_ph2;
      pub_tgl  <= ~pub_tgl;
    end
  end

  // ****************************************************************
  // crossing FIFO, write side in the link domain
  // ****************************************************************
  logic [DW-1:0] fifo_mem [FIFO_DEPTH];
  logic [PW-1:0] wptr_bin;
  logic [PW-1:0] wptr_gray;
  logic [PW-1:0] rptr_gray;
  logic [PW-1:0] rgray_q1;
  logic [PW-1:0] rgray_q2;
  logic          fifo_full;

  assign fifo_full = (wptr_gray == {~rgray_q2[PW-1:PW-2], rgray_q2[PW-3:0]});

  // one sample pair per rising edge; a full FIFO drops the pair
  always_ff @(posedge source_data_clock_i) begin
    rgray_q1 <= rptr_gray;
    rgray_q2 <= rgray_q1;
    if (lrst) begin
      wptr_bin  <= '0;
      wptr_gray <= '0;
    end else if (!fifo_full) begin
      fifo_mem[wptr_bin[PW-2:0]] <= {cap_ph2, cap_ph1};
      wptr_bin                   <= wptr_bin + 1'b1;
      wptr_gray                  <= bin2gray(wptr_bin + 1'b1);
    end
  end

  // ****************************************************************
  // crossing FIFO, read side in the system domain
  // ****************************************************************
  logic [PW-1:0] rptr_bin;
  logic [PW-1:0] wgray_q1;
  logic [PW-1:0] wgray_q2;
  logic          fifo_empty;
  logic          pop;
  logic [DW-1:0] pop_data;

  assign fifo_empty = (rptr_gray == wgray_q2);
  assign pop        = ce_i && !fifo_empty;
  assign pop_data   = fifo_mem[rptr_bin[PW-2:0]];

  // drain one pair per system cycle
  always_ff @(posedge sys_clk_i) begin
    if (ce_i) begin
      wgray_q1 <= wptr_gray;
      wgray_q2 <= wgray_q1;
    end
    if (srst_i) begin
      rptr_bin  <= '0;
      rptr_gray <= '0;
    end else if (pop) begin
      rptr_bin  <= rptr_bin + 1'b1;
      rptr_gray <= bin2gray(rptr_bin + 1'b1);
    end
  end

  // ****************************************************************
  // post-FIFO accumulators, converter side
  // ****************************************************************
  dpisb_sig u_post_ph1 (
    .clk_i     (sys_clk_i),
    .rst_i     (srst_i),
    .en_i      (ctl_post_en && ce_i),
    .clr_i     (ctl_clear),
    .smp_vld_i (pop),
    .smp_i     (pop_data[dpisb_pkg::SAMPLE_W-1:0]),
    .sig_o     (post_ph1)
  );

  dpisb_sig u_post_ph2 (
    .clk_i     (sys_clk_i),
    .rst_i     (srst_i),
    .en_i      (ctl_post_en && ce_i),
    .clr_i     (ctl_clear),
    .smp_vld_i (pop),
    .smp_i     (pop_data[DW-1:dpisb_pkg::SAMPLE_W]),
    .sig_o     (post_ph2)
  );

  // ****************************************************************
  // snapshot receiver and readback select
  // ****************************************************************
  logic [2:0] pub_q;

  // take the stable snapshot, then hand the token back
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      pub_q   <= '0;
      ack_tgl <= 1'b0;
      xs_ph1  <= dpisb_pkg::SIG_RESET;
      xs_ph2  <= dpisb_pkg::SIG_RESET;
    end else if (ce_i) begin
      pub_q <= {pub_q[1:0], pub_tgl};
      if (pub_q[1] != ack_tgl) begin
        xs_ph1  <= snap_ph1;
        xs_ph2  <= snap_ph2;
        ack_tgl <= ~ack_tgl;
      end
    end
  end

  // readback holder follows the selection while reading is enabled
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      rd_sig <= dpisb_pkg::SIG_RESET;
    end else if (ce_i && signature_read_enable) begin
      unique case (ctl_sel)
        dpisb_pkg::SEL_RX_PH1:   rd_sig <= xs_ph1;
        dpisb_pkg::SEL_RX_PH2:   rd_sig <= xs_ph2;
        dpisb_pkg::SEL_POST_PH1: rd_sig <= post_ph1;
        dpisb_pkg::SEL_POST_PH2: rd_sig <= post_ph2;
      endcase
    end
  end

  // ****************************************************************
  // serial register port
  // ****************************************************************
  logic [2:0] cs_q;
  logic [2:0] sclk_q;
  logic [1:0] sdi_q;
  logic [4:0] bit_cnt;
  logic [6:0] shift_in;
  logic       rd_op;
  logic [4:0] reg_addr;
  logic [7:0] out_q;
  logic       sclk_rise;
  logic       sclk_fall;
  logic       cs_act;
  logic [7:0] next_byte;

  assign cs_act    = !cs_q[1];
  assign sclk_rise = sclk_q[1] && !sclk_q[2];
  assign sclk_fall = !sclk_q[1] && sclk_q[2];
  assign next_byte = {shift_in, sdi_q[1]};

  // register read decode
  function automatic logic [7:0] reg_read(input logic [4:0] a);
    unique case (a)
      dpisb_pkg::ADDR_BIST_CTRL: return bist_ctrl;
      dpisb_pkg::ADDR_SIG_BYTE0: return rd_sig[7:0];
      dpisb_pkg::ADDR_SIG_BYTE1: return rd_sig[15:8];
      dpisb_pkg::ADDR_SIG_BYTE2: return rd_sig[23:16];
      dpisb_pkg::ADDR_SIG_BYTE3: return rd_sig[31:24];
      default:                   return dpisb_pkg::UNMAPPED_READ;
    endcase
  endfunction

  // pin synchronisers
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      cs_q   <= 3'h7;
      sclk_q <= 3'h0;
      sdi_q  <= 2'h0;
    end else if (ce_i) begin
      cs_q   <= {cs_q[1:0], spi_cs_n_i};
      sclk_q <= {sclk_q[1:0], spi_sclk_i};
      sdi_q  <= {sdi_q[0], spi_sdi_i};
    end
  end

  // frame: 8 instruction bits then 8 data bits, msb first
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      bit_cnt   <= '0;
      shift_in  <= '0;
      rd_op     <= 1'b0;
      reg_addr  <= '0;
      out_q     <= '0;
      bist_ctrl <= dpisb_pkg::CTRL_RESET;
    end else if (ce_i) begin
      if (!cs_act) begin
        bit_cnt <= '0;
        rd_op   <= 1'b0;
      end else if (sclk_rise && bit_cnt < dpisb_pkg::SPI_FRAME_BITS) begin
        shift_in <= next_byte[6:0];
        bit_cnt  <= bit_cnt + 1'b1;
        if (bit_cnt == dpisb_pkg::SPI_INSTR_BITS - 1'b1) begin
          rd_op    <= next_byte[dpisb_pkg::SPI_RW_BIT];
          reg_addr <= next_byte[4:0];
          out_q    <= reg_read(next_byte[4:0]);
        end
        if (bit_cnt == dpisb_pkg::SPI_FRAME_BITS - 1'b1 && !rd_op &&
            reg_addr == dpisb_pkg::ADDR_BIST_CTRL) begin
          bist_ctrl <= next_byte;
        end
      end else if (sclk_fall && bit_cnt > dpisb_pkg::SPI_INSTR_BITS) begin
        out_q <= {out_q[6:0], 1'b0};
      end
    end
  end

  assign spi_sdo_o    = out_q[7];
  assign spi_sdo_oe_o = cs_act && rd_op && (bit_cnt >= dpisb_pkg::SPI_INSTR_BITS);

endmodule // dpisb_top

/* File: rtl/dpisb_pkg.sv */
/*
  Constants for the dual-phase input signature self-test block:
  register offsets, control field positions, reset values, select codes
  and serial port framing. Assumes nothing of its surroundings.
*/
package dpisb_pkg;

  // ****************************************************************
  // widths
  // ****************************************************************
  localparam int SAMPLE_W = 14;
  localparam int SIG_W    = 32;
  localparam int REG_W    = 8;
  localparam int ADDR_W   = 5;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [ADDR_W-1:0] ADDR_BIST_CTRL = 5'h11;
  localparam logic [ADDR_W-1:0] ADDR_SIG_BYTE0 = 5'h12;
  localparam logic [ADDR_W-1:0] ADDR_SIG_BYTE1 = 5'h13;
  localparam logic [ADDR_W-1:0] ADDR_SIG_BYTE2 = 5'h14;
  localparam logic [ADDR_W-1:0] ADDR_SIG_BYTE3 = 5'h15;

  // ****************************************************************
  // control register fields and reset values
  // ****************************************************************
  localparam int CTRL_CLEAR_BIT   = 0;
  localparam int CTRL_POST_EN_BIT = 1;
  localparam int CTRL_RX_EN_BIT   = 2;
  localparam int CTRL_RD_EN_BIT   = 5;
  localparam int CTRL_SEL_LSB     = 6;
  localparam logic [REG_W-1:0] CTRL_RESET = 8'h00;
  localparam logic [SIG_W-1:0] SIG_RESET  = 32'h0000_0000;
  localparam logic [REG_W-1:0] UNMAPPED_READ = 8'h00;

  // ****************************************************************
  // signature select codes
  // ****************************************************************
  localparam logic [1:0] SEL_RX_PH1   = 2'h0;
  localparam logic [1:0] SEL_RX_PH2   = 2'h1;
  localparam logic [1:0] SEL_POST_PH1 = 2'h2;
  localparam logic [1:0] SEL_POST_PH2 = 2'h3;

  // ****************************************************************
  // serial port framing
  // ****************************************************************
  localparam logic [4:0] SPI_INSTR_BITS = 5'h08;
  localparam logic [4:0] SPI_FRAME_BITS = 5'h10;
  localparam int         SPI_RW_BIT     = 7;

  // ****************************************************************
  // one accumulator step for a nonzero sample
  // ****************************************************************
  function automatic logic [SIG_W-1:0] sig_step(input logic [SIG_W-1:0]    acc,
                                                 input logic [SAMPLE_W-1:0] smp);
    logic [SAMPLE_W-1:0] low;
    low = ~({acc[SAMPLE_W-2:0], acc[SIG_W-1]} ^ smp);
    return {acc[SIG_W-2:SAMPLE_W-1], low};
  endfunction

endpackage

/* File: rtl/dpisb_sig.sv */
/*
  One 32-bit signature accumulator.
  Assumes its clear and enable inputs are already in its own clock domain.
*/
`timescale 1ns/1ps
module dpisb_sig (
  input  wire logic                             clk_i,
  input  wire logic                             rst_i,
  input  wire logic                             en_i,
  input  wire logic                             clr_i,
  input  wire logic                             smp_vld_i,
  input  wire logic [dpisb_pkg::SAMPLE_W-1:0]   smp_i,
  output logic      [dpisb_pkg::SIG_W-1:0]      sig_o
);

  // ****************************************************************
  // accumulator
  // ****************************************************************
  // clear wins, zero sample and low enable hold the value
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sig_o <= dpisb_pkg::SIG_RESET;
    end else if (en_i && clr_i) begin
      sig_o <= dpisb_pkg::SIG_RESET;
    end else if (en_i && smp_vld_i && (smp_i != '0)) begin
      sig_o <= dpisb_pkg::sig_step(sig_o, smp_i);
    end
  end

endmodule // dpisb_sig

/* File: verif/dpisb_top_properties.sv */
/*
  Serial port checks for the signature self-test top, seen at its pins.
  Assumes cs_n opens each frame and sclk levels last several sys cycles.
*/
`timescale 1ns/1ps
module dpisb_top_properties #(
  parameter int FIFO_DEPTH = 4
) (
  input wire logic                           sys_clk_i,
  input wire logic                           srst_i,
  input wire logic                           ce_i,
  input wire logic                           source_data_clock_i,
  input wire logic [dpisb_pkg::SAMPLE_W-1:0] sample_data_i,
  input wire logic                           spi_cs_n_i,
  input wire logic                           spi_sclk_i,
  input wire logic                           spi_sdi_i,
  input wire logic                           spi_sdo_o,
  input wire logic                           spi_sdo_oe_o
);
  logic       sclk_q;
  logic       cs_n_q;
  logic [4:0] rise_cnt;
  logic       rd_frame;

  // ****************************************************************
  // pin-level frame tracking
  // ****************************************************************
  // counts sclk rises since cs fell, keeps the first bit (read flag)
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      sclk_q   <= 1'b0;
      cs_n_q   <= 1'b1;
      rise_cnt <= 5'h00;
      rd_frame <= 1'b0;
    end else begin
      sclk_q <= spi_sclk_i;
      cs_n_q <= spi_cs_n_i;
      if (cs_n_q && !spi_cs_n_i) begin
        rise_cnt <= 5'h00;
        rd_frame <= 1'b0;
      end else if (!spi_cs_n_i && spi_sclk_i && !sclk_q && rise_cnt != 5'h1f) begin
        rise_cnt <= rise_cnt + 5'h01;
        if (rise_cnt == 5'h00) begin
          rd_frame <= spi_sdi_i;
        end
      end
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);

  a_reset_quiet_pins: assert property ($fell(srst_i) |-> !spi_sdo_oe_o && !spi_sdo_o)
    else $error("sdo or its enable active out of reset");
  a_oe_idle_deselect: assert property (spi_cs_n_i [*4] |-> !spi_sdo_oe_o)
    else $error("sdo driven while deselected");
  a_oe_read_only: assert property (spi_sdo_oe_o |-> rd_frame && rise_cnt >= 5'h08)
    else $error("sdo driven outside a read data phase");
  a_oe_rise_bit8: assert property ($rose(spi_sdo_oe_o) |-> rise_cnt == 5'h08)
    else $error("sdo enable not raised after the eighth clock");
  a_oe_frame_bound: assert property (spi_sdo_oe_o |-> rise_cnt <= 5'h10)
    else $error("sdo driven past sixteen clocks");
  a_oe_stands_low: assert property (spi_sdo_oe_o && !spi_cs_n_i |=> spi_sdo_oe_o)
    else $error("sdo enable dropped while selected");
  a_oe_drop_cs: assert property ($fell(spi_sdo_oe_o) |->
      $past(spi_cs_n_i, 1) || $past(spi_cs_n_i, 2) || $past(spi_cs_n_i, 3))
    else $error("sdo enable dropped without deselect");
  a_sdo_shift_low: assert property ($changed(spi_sdo_o) && !spi_cs_n_i && rise_cnt >= 5'h09
      |-> !spi_sclk_i)
    else $error("sdo changed while sclk high");
endmodule // dpisb_top_properties

bind dpisb_top dpisb_top_properties #(.FIFO_DEPTH(FIFO_DEPTH)) dpisb_top_properties_inst (
  .sys_clk_i(sys_clk_i), .srst_i(srst_i), .ce_i(ce_i),
  .source_data_clock_i(source_data_clock_i), .sample_data_i(sample_data_i),
  .spi_cs_n_i(spi_cs_n_i), .spi_sclk_i(spi_sclk_i), .spi_sdi_i(spi_sdi_i),
  .spi_sdo_o(spi_sdo_o), .spi_sdo_oe_o(spi_sdo_oe_o));

/* File: verif/dpisb_source.sv */
/*
  Sample source model: free-running DDR clock, 160 ns period.
  Assumes the bench queues samples in pairs via push.
*/
`timescale 1ns/1ps
module dpisb_source (
  output logic                           clk_o,
  output logic [dpisb_pkg::SAMPLE_W-1:0] data_o
);
  logic [dpisb_pkg::SAMPLE_W-1:0] pend_q [$];
  logic [dpisb_pkg::SAMPLE_W-1:0] ph2;

  task automatic push(input logic [dpisb_pkg::SAMPLE_W-1:0] v);
    pend_q.push_back(v);
  endtask

  function automatic int pending();
    return pend_q.size();
  endfunction

  // ****************************************************************
  // clock and centred data
  // ****************************************************************
  // a pair goes out as rise then fall; idle value is zero
  initial begin
    clk_o  = 1'b0;
    data_o = '0;
    ph2    = '0;
    #7.3;
    forever begin
      if (pend_q.size() >= 2) begin
        data_o = pend_q.pop_front();
        ph2    = pend_q.pop_front();
      end else begin
        data_o = '0;
        ph2    = '0;
      end
      #40 clk_o = 1'b1;
      #40 data_o = ph2;
      #40 clk_o = 1'b0;
      #40;
    end
  end
endmodule // dpisb_source

/* File: verif/test_dpisb_top.sv */
/*
  Self-checking bench: serial register access, clear, random vectors
  against an integer signature model. Assumes the source model file.
*/
`timescale 1ns/1ps
module test_dpisb_top;
  logic        sys_clk;
  logic        srst;
  logic        ce;
  logic        link_clk;
  logic [13:0] sample_data;
  logic        cs_n;
  logic        sclk;
  logic        sdi;
  logic        sdo;
  logic        sdo_oe;
  logic [7:0]  r;
  logic [31:0] model_sig [2];
  int          bad_count;
  int          checks;

  dpisb_top dpisb_top_inst (.sys_clk_i(sys_clk), .srst_i(srst), .ce_i(ce),
    .source_data_clock_i(link_clk), .sample_data_i(sample_data), .spi_cs_n_i(cs_n),
    .spi_sclk_i(sclk), .spi_sdi_i(sdi), .spi_sdo_o(sdo), .spi_sdo_oe_o(sdo_oe));
  dpisb_source dpisb_source_inst (.clk_o(link_clk), .data_o(sample_data));

  // ****************************************************************
  // helpers
  // ****************************************************************
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic wait_sys(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic wait_link(input int n);
    repeat (n) @(posedge link_clk);
    wait_sys(1);
  endtask

  // one 16-clock frame, sdo taken just before rises 9 to 16
  task automatic spi_xfer(input logic [7:0] ins, input logic [7:0] wd, output logic [7:0] rd);
    logic [15:0] f;
    f = {ins, wd};
    rd = 8'h00;
    cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      sdi = f[i];
      wait_sys(6);
      if (i < 8) rd = {rd[6:0], sdo};
      sclk = 1'b1;
      wait_sys(6);
      sclk = 1'b0;
    end
    wait_sys(6);
    cs_n = 1'b1;
    wait_sys(6);
  endtask

  task automatic reg_write(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] x;
    spi_xfer({3'h0, a}, d, x);
  endtask

  task automatic reg_read(input logic [4:0] a, output logic [7:0] d);
    spi_xfer({3'h4, a}, 8'h00, d);
  endtask

  task automatic check_reg(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_sig(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [31:0] model_step(input logic [31:0] a, input logic [13:0] s);
    logic [31:0] n;
    if (s == 14'h0) return a;
    n = a << 1;
    n[0] = ~(a[31] ^ s[0]);
    for (int b = 1; b < 14; b++) n[b] = ~(a[b-1] ^ s[b]);
    return n;
  endfunction

  // reads the four bytes of every select, high byte first
  task automatic check_all();
    logic [31:0] s;
    for (int k = 0; k < 4; k++) begin
      reg_write(dpisb_pkg::ADDR_BIST_CTRL, {2'(k), 6'h26});
      wait_sys(10);
      for (int a = 3; a >= 0; a--) begin
        reg_read(dpisb_pkg::ADDR_SIG_BYTE0 + 5'(a), r);
        s[8*a +: 8] = r;
      end
      check_sig($sformatf("signature sel %0d", k), model_sig[k % 2], s);
    end
  endtask

  task automatic send_vector(input int n, input bit upd);
    logic [13:0] v;
    for (int i = 0; i < 2 * n; i++) begin
      v = (i % 7 == 3) ? 14'h0 : 14'($urandom());
      dpisb_source_inst.push(v);
      if (upd) model_sig[i % 2] = model_step(model_sig[i % 2], v);
    end
    for (int t = 0; t < 5000 && dpisb_source_inst.pending() != 0; t++) wait_sys(1);
    wait_link(20);
  endtask

  task automatic give_verdict();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    #2000000;
    bad_count++;
    give_verdict();
  end

  initial begin
    srst = 1'b1;
    ce = 1'b1;
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
    bad_count = 0;
    checks = 0;
    model_sig[0] = 32'h0;
    model_sig[1] = 32'h0;
    void'($urandom(32'h2918));
    wait_link(4);
    srst = 1'b0;
    wait_sys(4);
    reg_read(dpisb_pkg::ADDR_BIST_CTRL, r);
    check_reg("control reset", dpisb_pkg::CTRL_RESET, r);
    reg_read(dpisb_pkg::ADDR_SIG_BYTE0, r);
    check_reg("signature byte reset", dpisb_pkg::SIG_RESET[7:0], r);
    reg_read(5'h03, r);
    check_reg("unmapped read", dpisb_pkg::UNMAPPED_READ, r);
    $display("test reset done");
    reg_write(dpisb_pkg::ADDR_BIST_CTRL, 8'h07);
    wait_link(50);
    reg_write(dpisb_pkg::ADDR_BIST_CTRL, 8'h06);
    check_all();
    reg_read(dpisb_pkg::ADDR_BIST_CTRL, r);
    check_reg("control readback", 8'he6, r);
    $display("test clear done");
    send_vector(24, 1'b1);
    reg_write(dpisb_pkg::ADDR_SIG_BYTE2, 8'hff);
    check_all();
    $display("test vector done");
    // freeze the system side while only idle zeros arrive, then recheck
    ce = 1'b0;
    wait_sys(100);
    ce = 1'b1;
    wait_sys(10);
    check_all();
    $display("test clock enable done");
    reg_write(dpisb_pkg::ADDR_BIST_CTRL, 8'h00);
    send_vector(10, 1'b0);
    reg_write(dpisb_pkg::ADDR_BIST_CTRL, 8'h01);
    wait_link(20);
    check_all();
    $display("test hold done");
    send_vector(8, 1'b1);
    check_all();
    reg_write(dpisb_pkg::ADDR_BIST_CTRL, 8'h07);
    wait_link(50);
    reg_write(dpisb_pkg::ADDR_BIST_CTRL, 8'h06);
    model_sig[0] = 32'h0;
    model_sig[1] = 32'h0;
    check_all();
    $display("test accumulate and reclear done");
    give_verdict();
  end
endmodule // test_dpisb_top
